// ### logic/flash_cmd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_decoder #(
  parameter int ADDR_W = flash_cmd_pkg::ADDR_W_DEF,
  parameter int DATA_W = flash_cmd_pkg::DATA_W_DEF,
  parameter int BLK_SHIFT = flash_cmd_pkg::BLK_SHIFT_DEF,
  parameter int BANK_SHIFT = flash_cmd_pkg::BANK_SHIFT_DEF,
  parameter int BUF_WORDS = flash_cmd_pkg::BUF_WORDS_DEF,
  parameter int FACT_WORDS = flash_cmd_pkg::FACT_WORDS_DEF
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic bus_wr_i,
  input wire logic [ADDR_W-1:0] bus_addr_i,
  input wire logic [DATA_W-1:0] bus_data_i,
  input wire logic wp_b_i,
  input wire logic pwr_down_i,
  output logic op_start_o,
  output var flash_cmd_pkg::op_t op_kind_o,
  output logic [ADDR_W-1:0] op_addr_o,
  output logic [DATA_W-1:0] op_data_o,
  output logic word_valid_o,
  output logic op_refused_o,
  output logic suspend_o,
  output logic resume_o,
  output logic clear_status_o,
  output logic [flash_cmd_pkg::CFG_W-1:0] config_value_o,
  output logic [(1<<(ADDR_W-BLK_SHIFT))-1:0] block_locked_o,
  output logic [(1<<(ADDR_W-BLK_SHIFT))-1:0] block_lockdown_o,
  output logic [2*(1<<(ADDR_W-BANK_SHIFT))-1:0] bank_mode_o
);
  import flash_cmd_pkg::*;

  localparam int BLK_IDX_W = ADDR_W - BLK_SHIFT;
  localparam int BANK_IDX_W = ADDR_W - BANK_SHIFT;
  localparam int NBLK = 1 << BLK_IDX_W;
  localparam int NBANK = 1 << BANK_IDX_W;
  localparam int CNT_W = $clog2(BUF_WORDS);
  localparam int FCNT_W = $clog2(FACT_WORDS);
  localparam int SYNC_W = 3 + ADDR_W + DATA_W;

  generate
    if (BLK_SHIFT < 1 || BANK_SHIFT < BLK_SHIFT || BANK_SHIFT >= ADDR_W || ADDR_W < CFG_W ||
        DATA_W < CMD_W || BUF_WORDS < 2 || FACT_WORDS < 2 ||
        (1 << CNT_W) != BUF_WORDS || (1 << FCNT_W) != FACT_WORDS) begin : g_chk
      $error("flash_cmd_decoder parameters out of range");
    end
  endgenerate

  typedef struct packed {
    seq_t seq;
    logic wr_prev;
    logic [NBLK-1:0] locked;
    logic [NBLK-1:0] lockdown;
    read_mode_t [NBANK-1:0] mode;
    logic [ADDR_W-1:0] start_addr;
    logic [CNT_W-1:0] cnt;
    logic [FCNT_W-1:0] fcnt;
    logic op_start;
    op_t op_kind;
    logic [ADDR_W-1:0] op_addr;
    logic [DATA_W-1:0] op_data;
    logic word_valid;
    logic refused;
    logic suspend;
    logic resume;
    logic clr_status;
    logic [CFG_W-1:0] cfg;
  } state_t;

  state_t q, d;
  logic [1:0] rst_q;
  logic rst_n;
  logic [SYNC_W-1:0] sync_out;
  logic wr_s, wp_s, pd_s, wr_pulse;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic [CMD_W-1:0] cmd;
  logic [BLK_IDX_W-1:0] blk_w;
  logic [BANK_IDX_W-1:0] bank_w;
  logic ld_hold;

  ////////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  pin_sync #(.W(SYNC_W)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i({bus_wr_i, wp_b_i, pwr_down_i, bus_addr_i, bus_data_i}),
    .q_o(sync_out)
  );

  assign {wr_s, wp_s, pd_s, addr_s, data_s} = sync_out;
  assign wr_pulse = wr_s & ~q.wr_prev;
  assign cmd = data_s[CMD_W-1:0];
  assign blk_w = blk_of(addr_s);
  assign bank_w = bank_of(addr_s);
  assign ld_hold = q.lockdown[blk_w] & ~wp_s;

  function automatic logic [BLK_IDX_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:BLK_SHIFT];
  endfunction

  function automatic logic [BANK_IDX_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:BANK_SHIFT];
  endfunction

  // locked, or locked-down while write-protect is low
  function automatic logic guarded(input logic lk, input logic ld, input logic wph);
    return lk | (ld & ~wph);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // command decoder

  always_comb begin
    d = q;
    d.wr_prev = wr_s;
    d.op_start = 1'b0;
    d.word_valid = 1'b0;
    d.refused = 1'b0;
    d.suspend = 1'b0;
    d.resume = 1'b0;
    d.clr_status = 1'b0;
    if (pd_s) begin
      d.locked = '1;
      d.lockdown = '0;
      d.seq = SEQ_IDLE;
    end else if (wr_pulse) begin
      d.op_addr = addr_s;
      d.op_data = data_s;
      case (q.seq)
        SEQ_IDLE: begin
          d.start_addr = addr_s;
          if (cmd == CMD_READ_ARRAY) begin
            d.mode[bank_w] = MODE_ARRAY;
          end else if (cmd == CMD_READ_STATUS) begin
            d.mode[bank_w] = MODE_STATUS;
          end else if (cmd == CMD_READ_SIG) begin
            d.mode[bank_w] = MODE_SIG;
          end else if (cmd == CMD_READ_QUERY) begin
            d.mode[bank_w] = MODE_QUERY;
          end else if (cmd == CMD_CLR_STATUS) begin
            d.clr_status = 1'b1;
          end else if (cmd == CMD_SUSPEND) begin
            d.suspend = 1'b1;
          end else if (cmd == CMD_CONFIRM) begin
            d.resume = 1'b1;
          end else if (cmd == CMD_ERASE) begin
            d.seq = SEQ_ERASE;
          end else if (cmd == CMD_PROG_A || cmd == CMD_PROG_B) begin
            d.seq = SEQ_PROG;
          end else if (cmd == CMD_BUF_PROG) begin
            d.seq = SEQ_BUF_CNT;
          end else if (cmd == CMD_OTP_PROG) begin
            d.seq = SEQ_OTP;
          end else if (cmd == CMD_LOCK_SETUP) begin
            d.seq = SEQ_LOCK;
          end else if (cmd == CMD_BLANK) begin
            d.seq = SEQ_BLANK;
          end else if (cmd == CMD_FACTORY) begin
            d.seq = SEQ_FACT_SETUP;
          end
        end
        SEQ_ERASE: begin
          d.seq = SEQ_IDLE;
          if (cmd == CMD_CONFIRM) begin
            if (guarded(q.locked[blk_w], q.lockdown[blk_w], wp_s)) begin
              d.refused = 1'b1;
            end else begin
              d.op_start = 1'b1;
              d.op_kind = OP_ERASE;
              d.mode[bank_w] = MODE_STATUS;
            end
          end
        end
        SEQ_PROG: begin
          d.seq = SEQ_IDLE;
          if (guarded(q.locked[blk_w], q.lockdown[blk_w], wp_s)) begin
            d.refused = 1'b1;
          end else begin
            d.op_start = 1'b1;
            d.op_kind = OP_PROGRAM;
            d.mode[bank_w] = MODE_STATUS;
          end
        end
        SEQ_OTP: begin
          d.seq = SEQ_IDLE;
          d.op_start = 1'b1;
          d.op_kind = OP_OTP;
          d.mode[bank_w] = MODE_STATUS;
        end
        SEQ_BLANK: begin
          d.seq = SEQ_IDLE;
          if (cmd == CMD_BLANK_CONF) begin
            d.op_start = 1'b1;
            d.op_kind = OP_BLANK;
            d.mode[bank_w] = MODE_STATUS;
          end
        end
        SEQ_LOCK: begin
          d.seq = SEQ_IDLE;
          if (cmd == CMD_LOCK_CONF) begin
            if (!ld_hold) begin
              d.locked[blk_w] = 1'b1;
            end
          end else if (cmd == CMD_CONFIRM) begin
            if (!ld_hold) begin
              d.locked[blk_w] = 1'b0;
            end
          end else if (cmd == CMD_LOCKDOWN_CONF) begin
            if (!wp_s) begin
              d.lockdown[blk_w] = 1'b1;
            end
          end else if (cmd == CMD_CFG_CONF) begin
            d.cfg = addr_s[CFG_W-1:0];
          end
        end
        SEQ_BUF_CNT: begin
          if (data_s >= DATA_W'(BUF_WORDS)) begin
            d.seq = SEQ_IDLE;
          end else begin
            d.cnt = data_s[CNT_W-1:0];
            d.seq = SEQ_BUF_DATA;
          end
        end
        SEQ_BUF_DATA: begin
          d.word_valid = 1'b1;
          if (q.cnt == '0) begin
            d.seq = SEQ_BUF_CONF;
          end else begin
            d.cnt = q.cnt - 1'b1;
          end
        end
        SEQ_BUF_CONF: begin
          d.seq = SEQ_IDLE;
          if (cmd == CMD_CONFIRM) begin
            if (guarded(q.locked[blk_of(q.start_addr)], q.lockdown[blk_of(q.start_addr)],
                        wp_s)) begin
              d.refused = 1'b1;
            end else begin
              d.op_start = 1'b1;
              d.op_kind = OP_BUFFER;
              d.op_addr = q.start_addr;
              d.mode[bank_of(q.start_addr)] = MODE_STATUS;
            end
          end
        end
        SEQ_FACT_SETUP: begin
          d.seq = SEQ_IDLE;
          if (cmd == CMD_CONFIRM) begin
            if (guarded(q.locked[blk_w], q.lockdown[blk_w], wp_s)) begin
              d.refused = 1'b1;
            end else begin
              d.start_addr = addr_s;
              d.fcnt = '0;
              d.op_start = 1'b1;
              d.op_kind = OP_FACTORY;
              d.seq = SEQ_FACT_DATA;
              d.mode[bank_w] = MODE_STATUS;
            end
          end
        end
        SEQ_FACT_DATA: begin
          if (blk_w != blk_of(q.start_addr)) begin
            d.seq = SEQ_IDLE;
            d.op_start = 1'b1;
            d.op_kind = OP_FACT_EXIT;
            d.refused = (q.fcnt != '0);
          end else if (addr_s == q.start_addr) begin
            d.word_valid = 1'b1;
            d.fcnt = q.fcnt + 1'b1;
          end
        end
        default: begin
          d.seq = SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.locked <= '1;
    end else begin
      q <= d;
    end
  end

  assign op_start_o = q.op_start;
  assign op_kind_o = q.op_kind;
  assign op_addr_o = q.op_addr;
  assign op_data_o = q.op_data;
  assign word_valid_o = q.word_valid;
  assign op_refused_o = q.refused;
  assign suspend_o = q.suspend;
  assign resume_o = q.resume;
  assign clear_status_o = q.clr_status;
  assign config_value_o = q.cfg;
  assign block_locked_o = q.locked;
  assign block_lockdown_o = q.lockdown;
  assign bank_mode_o = q.mode;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  logic lock_wr;
  assign lock_wr = wr_pulse && !pd_s && q.seq == SEQ_LOCK;

  unlock_clears_a: assert property (
    lock_wr && cmd == CMD_CONFIRM && !ld_hold |=> !q.locked[$past(blk_w)])
    else $error("unlock did not clear block lock");
  lockdown_sets_a: assert property (
    lock_wr && cmd == CMD_LOCKDOWN_CONF && !wp_s |=> q.lockdown[$past(blk_w)])
    else $error("lock-down did not mark block");
  ld_keeps_lock_a: assert property (
    lock_wr && cmd == CMD_LOCKDOWN_CONF |=> q.locked == $past(q.locked))
    else $error("lock-down changed lock bits");
  prog_refused_a: assert property (
    wr_pulse && !pd_s && q.seq == SEQ_PROG && q.lockdown[blk_w] && !wp_s
    |=> op_refused_o && !op_start_o)
    else $error("program on locked-down block not refused");
  wp_freeze_a: assert property (
    lock_wr && ld_hold |=> q.locked[$past(blk_w)] == $past(q.locked[blk_w]))
    else $error("lock state changed under write-protect");
  wp_high_ld_a: assert property (
    lock_wr && wp_s |=> q.lockdown == $past(q.lockdown))
    else $error("lock-down acted with write-protect high");
  pd_revert_a: assert property (
    pd_s |=> q.lockdown == '0 && (&q.locked))
    else $error("power-down did not revert lock-down");
  status_mode_a: assert property (
    wr_pulse && !pd_s && q.seq == SEQ_IDLE && cmd == CMD_READ_STATUS
    |=> q.mode[$past(bank_w)] == MODE_STATUS)
    else $error("status mode not selected");
  clr_pulse_a: assert property (
    wr_pulse && !pd_s && q.seq == SEQ_IDLE && cmd == CMD_CLR_STATUS
    |=> clear_status_o ##1 !clear_status_o)
    else $error("clear status pulse wrong");
  mismatch_a: assert property (
    wr_pulse && !pd_s && q.seq == SEQ_ERASE && cmd != CMD_CONFIRM
    |=> !op_start_o && q.seq == SEQ_IDLE && $stable(q.locked))
    else $error("mismatched confirm not discarded");
  fact_exit_a: assert property (
    wr_pulse && !pd_s && q.seq == SEQ_FACT_DATA && blk_w != blk_of(q.start_addr)
    |=> op_start_o && op_kind_o == OP_FACT_EXIT)
    else $error("factory exit not signalled");

  erase_cov_c: cover property (op_start_o && op_kind_o == OP_ERASE);
  buffer_cov_c: cover property (op_start_o && op_kind_o == OP_BUFFER);
  lockdown_cov_c: cover property (lock_wr && cmd == CMD_LOCKDOWN_CONF && !wp_s);
  factory_cov_c: cover property (op_start_o && op_kind_o == OP_FACT_EXIT && !op_refused_o);
endmodule
`default_nettype wire

// ### logic/flash_cmd_pkg.sv
`default_nettype none
package flash_cmd_pkg;
  localparam int ADDR_W_DEF = 23;
  localparam int DATA_W_DEF = 16;
  localparam int BLK_SHIFT_DEF = 16;
  localparam int BANK_SHIFT_DEF = 19;
  localparam int BUF_WORDS_DEF = 32;
  localparam int FACT_WORDS_DEF = 32;
  localparam int CFG_W = 16;
  localparam int CMD_W = 8;
  localparam logic [CMD_W-1:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [CMD_W-1:0] CMD_READ_STATUS = 8'h70;
  localparam logic [CMD_W-1:0] CMD_READ_SIG = 8'h90;
  localparam logic [CMD_W-1:0] CMD_READ_QUERY = 8'h98;
  localparam logic [CMD_W-1:0] CMD_CLR_STATUS = 8'h50;
  localparam logic [CMD_W-1:0] CMD_ERASE = 8'h20;
  localparam logic [CMD_W-1:0] CMD_PROG_A = 8'h40;
  localparam logic [CMD_W-1:0] CMD_PROG_B = 8'h10;
  localparam logic [CMD_W-1:0] CMD_BUF_PROG = 8'hE8;
  localparam logic [CMD_W-1:0] CMD_SUSPEND = 8'hB0;
  localparam logic [CMD_W-1:0] CMD_CONFIRM = 8'hD0;
  localparam logic [CMD_W-1:0] CMD_OTP_PROG = 8'hC0;
  localparam logic [CMD_W-1:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [CMD_W-1:0] CMD_CFG_CONF = 8'h03;
  localparam logic [CMD_W-1:0] CMD_LOCK_CONF = 8'h01;
  localparam logic [CMD_W-1:0] CMD_LOCKDOWN_CONF = 8'h2F;
  localparam logic [CMD_W-1:0] CMD_BLANK = 8'hBC;
  localparam logic [CMD_W-1:0] CMD_BLANK_CONF = 8'hCB;
  localparam logic [CMD_W-1:0] CMD_FACTORY = 8'h80;
  typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_SIG, MODE_QUERY} read_mode_t;
  typedef enum logic [2:0] {
    OP_NONE, OP_ERASE, OP_PROGRAM, OP_BUFFER, OP_OTP, OP_BLANK, OP_FACTORY, OP_FACT_EXIT
  } op_t;
  typedef enum logic [3:0] {
    SEQ_IDLE, SEQ_ERASE, SEQ_PROG, SEQ_LOCK, SEQ_OTP, SEQ_BLANK, SEQ_FACT_SETUP,
    SEQ_FACT_DATA, SEQ_BUF_CNT, SEQ_BUF_DATA, SEQ_BUF_CONF
  } seq_t;
endpackage
`default_nettype wire

// ### logic/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t q, d;

  generate
    if (W < 1) begin : g_chk
      $error("pin_sync width must be positive");
    end
  endgenerate

  always_comb begin
    d.s1 = d_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign q_o = q.s2;
endmodule
`default_nettype wire

// ### test/flash_host.sv
`timescale 1ns/1ns
`default_nettype none
module flash_host (
  input wire logic clk_i,
  output logic bus_wr_o,
  output logic [22:0] bus_addr_o,
  output logic [15:0] bus_data_o
);
  initial begin
    bus_wr_o = 1'b0;
    bus_addr_o = 23'h000000;
    bus_data_o = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one bus write; two-write sequences are built from these
  task automatic put(input logic [22:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus_addr_o <= a;
    bus_data_o <= d;
    repeat (3) @(posedge clk_i);
    bus_wr_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    bus_wr_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    // released bus shows inverse, not the held value
    bus_addr_o <= ~a;
    bus_data_o <= ~d;
    repeat (2) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### test/tb_flash_command_decoder_block_protect.sv
`timescale 1ns/1ns
`default_nettype none
module tb_flash_command_decoder_block_protect;
  import flash_cmd_pkg::*;
  logic clk, rst_b, wp, pd, bus_wr, op_start, wvalid, refused, susp, res, clr;
  logic [22:0] bus_addr, op_addr, s_addr, e_addr, m_start, w_addr;
  logic [15:0] bus_data, op_data, s_data, e_data, cfg, w_data;
  logic [7:0] c2;
  op_t op_kind, s_kind, e_kind;
  logic [127:0] locked, lockdown, m_lk, m_ld;
  logic [31:0] mode, r;
  logic [1:0] m_mode [16];
  int fail_count, samples_checked, n_start, n_ref, n_sus, n_res, n_clr;
  int e_start, e_ref, e_sus, e_res, e_clr, seq, m_cnt, m_fc, n_wv, e_wv;
  integer seed;
  initial clk = 1'b0;
  always #2 clk = ~clk;
  flash_host host (.clk_i(clk), .bus_wr_o(bus_wr), .bus_addr_o(bus_addr), .bus_data_o(bus_data));
  flash_cmd_decoder dut (
    .clk_i(clk), .rst_b_i(rst_b), .bus_wr_i(bus_wr), .bus_addr_i(bus_addr),
    .bus_data_i(bus_data), .wp_b_i(wp), .pwr_down_i(pd), .op_start_o(op_start),
    .op_kind_o(op_kind), .op_addr_o(op_addr), .op_data_o(op_data), .word_valid_o(wvalid),
    .op_refused_o(refused), .suspend_o(susp), .resume_o(res), .clear_status_o(clr),
    .config_value_o(cfg), .block_locked_o(locked), .block_lockdown_o(lockdown),
    .bank_mode_o(mode)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // pulse counters
  always @(posedge clk) begin
    if (op_start === 1'b1) begin
      n_start <= n_start + 1;
      s_kind <= op_kind;
      s_addr <= op_addr;
      s_data <= op_data;
    end
    if (wvalid === 1'b1) begin
      n_wv <= n_wv + 1;
      w_addr <= op_addr;
      w_data <= op_data;
    end
    if (refused === 1'b1) n_ref <= n_ref + 1;
    if (susp === 1'b1) n_sus <= n_sus + 1;
    if (res === 1'b1) n_res <= n_res + 1;
    if (clr === 1'b1) n_clr <= n_clr + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [22:0] ba(input int b, input int o);
    return {b[6:0], o[15:0]};
  endfunction
  task automatic set_wp(input logic v);
    @(posedge clk);
    wp <= v;
    repeat (4) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reference model: one write, then compare
  task automatic mw(input logic [22:0] a, input logic [15:0] d);
    int blk, bank, nxt, mb;
    logic [7:0] c;
    logic hold, prot, msel, gd, wv;
    op_t k;
    blk = a[22:16];
    bank = a[22:19];
    mb = bank;
    wv = 1'b0;
    c = d[7:0];
    hold = m_ld[blk] & ~wp;
    prot = m_lk[blk] | hold;
    msel = 1'b0;
    nxt = 0;
    k = OP_NONE;
    gd = 1'b0;
    host.put(a, d);
    case (seq)
      0: case (c)
        8'hFF, 8'h70, 8'h90, 8'h98: begin
          m_mode[bank] = (c == 8'hFF) ? 2'h0 : (c == 8'h70) ? 2'h1 : (c == 8'h90) ? 2'h2 : 2'h3;
          msel = 1'b1;
        end
        8'h50: e_clr++;
        8'hB0: e_sus++;
        8'hD0: e_res++;
        8'h20: nxt = 1;
        8'h40, 8'h10: nxt = 2;
        8'h60: nxt = 3;
        8'hC0: nxt = 4;
        8'hBC: nxt = 5;
        8'hE8: begin
          nxt = 6;
          m_start = a;
        end
        8'h80: nxt = 8;
        default: ;
      endcase
      1: if (c == 8'hD0) begin
        k = OP_ERASE;
        gd = prot;
      end
      2: begin
        k = OP_PROGRAM;
        gd = prot;
      end
      3: case (c)
        8'h01: if (!hold) m_lk[blk] = 1'b1;
        8'hD0: if (!hold) m_lk[blk] = 1'b0;
        8'h2F: if (!wp) m_ld[blk] = 1'b1;
        8'h03: check(cfg, a[15:0]);
        default: ;
      endcase
      4: k = OP_OTP;
      5: if (c == 8'hCB) k = OP_BLANK;
      6: if (d < BUF_WORDS_DEF) begin
        m_cnt = d;
        nxt = 7;
      end
      7: begin
        wv = 1'b1;
        nxt = (m_cnt == 0) ? 9 : 7;
        m_cnt--;
      end
      9: if (c == 8'hD0) begin
        k = OP_BUFFER;
        mb = m_start[22:19];
        gd = m_lk[m_start[22:16]] | (m_ld[m_start[22:16]] & ~wp);
      end
      8: if (c == 8'hD0) begin
        k = OP_FACTORY;
        gd = prot;
        if (!prot) begin
          nxt = 10;
          m_start = a;
          m_fc = 0;
        end
      end
      10: begin
        nxt = 10;
        if (a[22:16] != m_start[22:16]) begin
          k = OP_FACT_EXIT;
          nxt = 0;
          if (m_fc % FACT_WORDS_DEF != 0) e_ref++;
        end else if (a == m_start) begin
          wv = 1'b1;
          m_fc++;
        end
      end
      default: ;
    endcase
    seq = nxt;
    if (k != OP_NONE && gd) e_ref++;
    if (k != OP_NONE && !gd) begin
      e_start++;
      e_kind = k;
      e_addr = (k == OP_BUFFER) ? m_start : a;
      e_data = d;
      if (k != OP_FACT_EXIT) begin
        m_mode[mb] = 2'h1;
        msel = 1'b1;
      end
    end
    if (wv) e_wv++;
    check(n_start, e_start);
    check(n_ref, e_ref);
    check({n_sus, n_res, n_clr}, {e_sus, e_res, e_clr});
    check(locked, m_lk);
    check(lockdown, m_ld);
    if (e_start > 0) check({s_kind, s_addr, s_data}, {e_kind, e_addr, e_data});
    if (msel) check(mode[2*mb+:2], m_mode[mb]);
    check(n_wv, e_wv);
    if (wv) check({w_addr, w_data}, {a, d});
  endtask
  task automatic pair(input logic [22:0] a1, input logic [7:0] c1, input logic [22:0] a2,
                      input logic [15:0] d2);
    mw(a1, {8'h00, c1});
    mw(a2, d2);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h2527;
    rst_b = 1'b0;
    wp = 1'b0;
    pd = 1'b0;
    m_lk = '1;
    m_ld = '0;
    foreach (m_mode[i]) m_mode[i] = 2'h0;
    seq = 0;
    e_kind = OP_NONE;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    check(locked, m_lk);
    check(lockdown, m_ld);
    pair(ba(5, 0), 8'h20, ba(5, 0), 16'h00D0);
    pair(ba(6, 0), 8'h60, ba(5, 0), 16'h00D0);
    pair(ba(7, 16'h0AAA), 8'h20, ba(5, 0), 16'h00D0);
    r = $random(seed);
    pair(ba(5, 0), 8'h40, ba(5, 16'h0042), r[15:0]);
    pair(ba(4, 1), 8'h10, ba(5, 16'h0043), r[31:16]);
    for (int i = 0; i < 16; i++) mw(ba(8 * i, 0), 16'h0070);
    mw(ba(40, 0), 16'h0070);
    mw(ba(40, 0), 16'h0090);
    mw(ba(40, 0), 16'h0098);
    mw(ba(40, 0), 16'h00FF);
    mw(ba(1, 0), 16'h0050);
    mw(ba(99, 0), 16'h00B0);
    mw(ba(77, 0), 16'h00D0);
    pair(ba(0, 16'hA5C3), 8'h60, ba(0, 16'hA5C3), 16'h0003);
    pair(ba(5, 0), 8'h60, ba(5, 0), 16'h0001);
    pair(ba(5, 0), 8'h60, ba(5, 0), 16'h002F);
    pair(ba(9, 0), 8'h60, ba(9, 0), 16'h00D0);
    pair(ba(9, 0), 8'h60, ba(9, 0), 16'h002F);
    pair(ba(9, 0), 8'h40, ba(9, 16'h0010), 16'h1234);
    pair(ba(9, 0), 8'h20, ba(9, 0), 16'h00D0);
    pair(ba(5, 0), 8'h60, ba(5, 0), 16'h00D0);
    pair(ba(9, 0), 8'h60, ba(9, 0), 16'h0001);
    set_wp(1'b1);
    pair(ba(5, 0), 8'h60, ba(5, 0), 16'h00D0);
    pair(ba(9, 0), 8'h40, ba(9, 16'h0011), 16'h4321);
    pair(ba(12, 0), 8'h60, ba(12, 0), 16'h002F);
    pair(ba(9, 0), 8'h20, ba(9, 0), 16'h0001);
    pair(ba(5, 0), 8'h60, ba(5, 0), 16'h0055);
    pair(ba(2, 16'h0081), 8'hC0, ba(2, 16'h0081), r[15:0]);
    pair(ba(9, 0), 8'hBC, ba(9, 0), 16'h00CB);
    pair(ba(5, 0), 8'hE8, ba(5, 0), 16'h0003);
    for (int i = 0; i < 4; i++) mw(ba(5, 16'h0100 + i), r[15:0] ^ 16'(i));
    mw(ba(5, 0), 16'h00D0);
    pair(ba(5, 0), 8'hE8, ba(5, 0), 16'h0020);
    pair(ba(3, 0), 8'hE8, ba(3, 0), 16'h0000);
    pair(ba(3, 7), 8'h11, ba(3, 0), 16'h00D0);
    pair(ba(9, 0), 8'h80, ba(9, 16'h0200), 16'h00D0);
    repeat (32) begin
      r = $random(seed);
      mw(ba(9, 16'h0200), r[15:0]);
    end
    mw(ba(9, 16'h0201), 16'h5A5A);
    mw(ba(10, 0), 16'h0000);
    pair(ba(9, 0), 8'h80, ba(9, 16'h0300), 16'h00D0);
    repeat (3) mw(ba(9, 16'h0300), r[31:16]);
    mw(ba(20, 0), 16'h0000);
    set_wp(1'b0);
    pair(ba(9, 0), 8'h60, ba(9, 0), 16'h002F);
    @(posedge clk);
    pd <= 1'b1;
    repeat (8) @(posedge clk);
    pd <= 1'b0;
    repeat (4) @(posedge clk);
    m_lk = '1;
    m_ld = '0;
    check(locked, m_lk);
    check(lockdown, m_ld);
    repeat (60) begin
      r = $random(seed);
      case (r[9:8])
        0: begin
          c2 = r[12] ? 8'h2F : r[11] ? 8'h01 : 8'hD0;
          pair(ba(r[1:0], r[31:16]), 8'h60, ba(r[3:2], 0), {8'h00, c2});
        end
        1: pair(ba(r[1:0], 0), 8'h20, ba(r[1:0], r[31:16]), 16'h00D0);
        2: pair(ba(r[3:2], 0), 8'h40, ba(r[3:2], r[31:16]), r[15:0]);
        default: set_wp(r[13]);
      endcase
    end
    wrap_up;
  end
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
